// >>> tile_control_debug_regs.sv
// Tile control and debug register bank with media clock and delay logic.
// Assumes an APB3 master, pclk standing in for the PLL output, and
// thread-state inputs synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module tile_control_debug_regs #(
    parameter int ADDR_W = 8,
    parameter int MDATA_W = 4
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // RAM address builder
    input wire logic [15:0] ram_offset,
    output logic [31:0] ram_addr,
    // Event and interrupt vectoring
    input wire logic event_req,
    input wire logic [15:0] event_vector,
    output logic [31:0] vector_addr,
    output logic vector_valid,
    // Media port transmit side
    input wire logic [MDATA_W-1:0] media_tx_data_in,
    output logic [MDATA_W-1:0] media_tx_data,
    output logic media_tx_clk,
    output logic media_ports_en,
    // Low-power clock divider
    input wire logic all_threads_paused,
    output logic lp_divider_active,
    // Thread state and debugger entry
    input wire logic debug_entry,
    input wire logic kernel_entry,
    input wire logic [tile_regs_pkg::SSW_W-1:0] saved_status_word,
    input wire logic [31:0] saved_program_counter,
    input wire logic [31:0] saved_stack_pointer,
    output logic issue_mode_bit,
    output logic thread_irq_en,
    output logic thread_evt_en
);

    localparam int SSW_W_P = tile_regs_pkg::SSW_W;
    localparam int DLY_W = tile_regs_pkg::CTL_DELAY_W;
    localparam int DIV_W = tile_regs_pkg::CTL_DIV_W;
    localparam int DEPTH = (1 << DLY_W) - 1;

    // Map a byte address onto a register index; odd lanes never hit
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = a >> 2;
        reg_index = w[7:0];
    endfunction : reg_index

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = reg_index(a);
        addr_hit = (a[1:0] == 2'h0) && (
            i == tile_regs_pkg::IDX_RAM_BASE ||
            i == tile_regs_pkg::IDX_VECTOR_BASE ||
            i == tile_regs_pkg::IDX_TILE_CONTROL ||
            i == tile_regs_pkg::IDX_DBG_STATUS ||
            i == tile_regs_pkg::IDX_DBG_PC ||
            i == tile_regs_pkg::IDX_DBG_SP);
    endfunction : addr_hit

    // Masked update keeps read-only bits at their stored value
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction : merge

    logic [31:0] ram_base_q;
    logic [31:0] vector_base_q;
    logic [31:0] tile_control_q;
    logic [31:0] dbg_status_q;
    logic [31:0] dbg_pc_q;
    logic [31:0] dbg_sp_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] ram_addr_q;
    logic [31:0] vector_addr_q;
    logic vector_valid_q;
    logic [DIV_W-1:0] div_cnt_q;
    logic media_clk_q;
    logic [MDATA_W-1:0] media_data_q;
    logic lp_active_q;
    logic issue_mode_q;
    logic [MDATA_W-1:0] delay_line [0:DEPTH-1];

    logic access;
    logic commit_wr;
    logic [7:0] idx;
    logic [31:0] rdata_d;
    logic [DLY_W-1:0] tx_delay;
    logic [DIV_W-1:0] tx_div;
    logic media_en;

    assign idx = reg_index(paddr);
    assign access = psel && penable && !pready_q;
    // Write lands only on the edge that completes the transfer
    assign commit_wr = psel && penable && pready_q && pwrite && addr_hit(paddr);
    assign tx_delay = tile_control_q[tile_regs_pkg::CTL_DELAY_LSB +: DLY_W];
    assign tx_div = tile_control_q[tile_regs_pkg::CTL_DIV_LSB +: DIV_W];
    assign media_en = tile_control_q[tile_regs_pkg::CTL_MEDIA_EN];

    // Read mux; issue mode bit is live, bit 5 and 31:11 are zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (idx)
            tile_regs_pkg::IDX_RAM_BASE: rdata_d = ram_base_q;
            tile_regs_pkg::IDX_VECTOR_BASE: rdata_d = vector_base_q;
            tile_regs_pkg::IDX_TILE_CONTROL: rdata_d = tile_control_q;
            tile_regs_pkg::IDX_DBG_STATUS: begin
                rdata_d = dbg_status_q & tile_regs_pkg::WMASK_DBG_STATUS;
                rdata_d[tile_regs_pkg::SSW_ISSUE_MODE] = issue_mode_q;
            end
            tile_regs_pkg::IDX_DBG_PC: rdata_d = dbg_pc_q;
            tile_regs_pkg::IDX_DBG_SP: rdata_d = dbg_sp_q;
            default: rdata_d = 32'h0000_0000;
        endcase
        if (!addr_hit(paddr)) begin
            rdata_d = 32'h0000_0000;
        end
    end

    // One wait state: pready rises the cycle after the access phase opens
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (access) begin
            pready_q <= 1'b1;
            pslverr_q <= !addr_hit(paddr);
            prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_base_q <= tile_regs_pkg::RST_RAM_BASE;
        end else if (commit_wr && idx == tile_regs_pkg::IDX_RAM_BASE) begin
            ram_base_q <= merge(ram_base_q, pwdata, tile_regs_pkg::WMASK_RAM_BASE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_base_q <= tile_regs_pkg::RST_VECTOR_BASE;
        end else if (commit_wr && idx == tile_regs_pkg::IDX_VECTOR_BASE) begin
            vector_base_q <= merge(vector_base_q, pwdata,
                                   tile_regs_pkg::WMASK_VECTOR_BASE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tile_control_q <= tile_regs_pkg::RST_TILE_CONTROL;
        end else if (commit_wr && idx == tile_regs_pkg::IDX_TILE_CONTROL) begin
            tile_control_q <= merge(tile_control_q, pwdata,
                                    tile_regs_pkg::WMASK_TILE_CONTROL);
        end
    end

    // Debugger entry beats a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_status_q <= tile_regs_pkg::RST_DBG;
        end else if (debug_entry) begin
            dbg_status_q <= {21'h0, saved_status_word}
                            & tile_regs_pkg::WMASK_DBG_STATUS;
        end else if (commit_wr && idx == tile_regs_pkg::IDX_DBG_STATUS) begin
            dbg_status_q <= merge(dbg_status_q, pwdata,
                                  tile_regs_pkg::WMASK_DBG_STATUS);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_pc_q <= tile_regs_pkg::RST_DBG;
        end else if (debug_entry) begin
            dbg_pc_q <= saved_program_counter;
        end else if (commit_wr && idx == tile_regs_pkg::IDX_DBG_PC) begin
            dbg_pc_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_sp_q <= tile_regs_pkg::RST_DBG;
        end else if (debug_entry) begin
            dbg_sp_q <= saved_stack_pointer;
        end else if (commit_wr && idx == tile_regs_pkg::IDX_DBG_SP) begin
            dbg_sp_q <= pwdata;
        end
    end

    // Kernel entry adopts the issue mode chosen by status bit 9
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            issue_mode_q <= 1'b0;
        end else if (kernel_entry) begin
            issue_mode_q <= dbg_status_q[tile_regs_pkg::SSW_ENTRY_MODE];
        end
    end

    // Address builders
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_addr_q <= 32'h0000_0000;
        end else begin
            ram_addr_q <= {ram_base_q[31:tile_regs_pkg::ADDR_HALF], ram_offset};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_addr_q <= 32'h0000_0000;
            vector_valid_q <= 1'b0;
        end else begin
            vector_valid_q <= event_req;
            if (event_req) begin
                vector_addr_q <= {vector_base_q[31:tile_regs_pkg::ADDR_HALF],
                                  event_vector};
            end
        end
    end

    // Media transmit clock; divider value holds ratio minus one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= '0;
            media_clk_q <= 1'b0;
        end else if (!media_en) begin
            div_cnt_q <= '0;
            media_clk_q <= 1'b0;
        end else begin
            div_cnt_q <= (div_cnt_q >= tx_div) ? '0 : div_cnt_q + 1'b1;
            if (div_cnt_q == tx_div) begin
                media_clk_q <= 1'b1;
            end else if (div_cnt_q == (tx_div >> 1)) begin
                media_clk_q <= 1'b0;
            end
        end
    end

    // Delay line holds no reset; stale words only appear in the first tx_delay cycles after reset
    always_ff @(posedge pclk) begin
        delay_line[0] <= media_tx_data_in;
        for (int i = 1; i < DEPTH; i++) begin
            delay_line[i] <= delay_line[i-1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            media_data_q <= '0;
        end else if (!media_en) begin
            media_data_q <= '0;
        end else if (tx_delay == '0) begin
            media_data_q <= media_tx_data_in;
        end else begin
            media_data_q <= delay_line[tx_delay - 1'b1];
        end
    end

    // Low-power divider engage; static mode keeps it on continuously
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_active_q <= 1'b0;
        end else begin
            lp_active_q <= tile_control_q[tile_regs_pkg::CTL_LP_EN] &&
                           (!tile_control_q[tile_regs_pkg::CTL_DYNAMIC] ||
                            all_threads_paused);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign ram_addr = ram_addr_q;
    assign vector_addr = vector_addr_q;
    assign vector_valid = vector_valid_q;
    assign media_tx_clk = media_clk_q;
    assign media_tx_data = media_data_q;
    assign media_ports_en = tile_control_q[tile_regs_pkg::CTL_MEDIA_EN];
    assign lp_divider_active = lp_active_q;
    assign issue_mode_bit = issue_mode_q;
    assign thread_irq_en = dbg_status_q[tile_regs_pkg::SSW_IRQ_EN];
    assign thread_evt_en = dbg_status_q[tile_regs_pkg::SSW_EVT_EN];

endmodule : tile_control_debug_regs

`default_nettype wire

// >>> tile_regs_pkg.sv
// Constants for the tile control and debug register bank.
// Assumes an APB3 master on the register side and a single 250 MHz clock.
// Functional notes
// - RAM base resets to 0x00040000
// - RAM base bits 31:2 writable, bits 31:16 give address top
// - Vector address: base top half, event vector low
// - Vector base writable 31:18, rest read zero
// - Control 25:18 delays media transmit data in cycles
// - Media clock high at divider value, low at half
// - Control bit 8 enables media ports
// - Dynamic mode engages divider only when all paused
// - Control bit 4 enables low-power clock divider
// - Status bit 7 shows fast issue mode
// - Status bit 6 shows thread paused waiting
// - Status bit 4 shows kernel mode
// - Status bit 3 shows interrupt handler active
// - Status bit 2 shows event enabling sequence
// - Status bit 1 permits thread interrupts
// - Status bit 0 permits thread events
// - Status bit 9 selects entry mode, 8 reports current
// - Debugger entry captures saved program counter
// - Debugger entry captures saved stack pointer

`default_nettype none

package tile_regs_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_RAM_BASE = 8'h00;
    localparam logic [7:0] IDX_VECTOR_BASE = 8'h01;
    localparam logic [7:0] IDX_TILE_CONTROL = 8'h02;
    localparam logic [7:0] IDX_DBG_STATUS = 8'h10;
    localparam logic [7:0] IDX_DBG_PC = 8'h11;
    localparam logic [7:0] IDX_DBG_SP = 8'h12;

    // Reset values
    localparam logic [31:0] RST_RAM_BASE = 32'h0004_0000;
    localparam logic [31:0] RST_VECTOR_BASE = 32'h0000_0000;
    localparam logic [31:0] RST_TILE_CONTROL = 32'h0000_0000;
    localparam logic [31:0] RST_DBG = 32'h0000_0000;

    // Writable bits per register
    localparam logic [31:0] WMASK_RAM_BASE = 32'hffff_fffc;
    localparam logic [31:0] WMASK_VECTOR_BASE = 32'hfffc_0000;
    localparam logic [31:0] WMASK_TILE_CONTROL = 32'h03ff_ff30;
    localparam logic [31:0] WMASK_DBG_STATUS = 32'h0000_06df;

    // Tile control fields
    localparam int CTL_DELAY_LSB = 18;
    localparam int CTL_DELAY_W = 8;
    localparam int CTL_DIV_LSB = 9;
    localparam int CTL_DIV_W = 9;
    localparam int CTL_MEDIA_EN = 8;
    localparam int CTL_DYNAMIC = 5;
    localparam int CTL_LP_EN = 4;

    // Saved status word fields
    localparam int SSW_W = 11;
    localparam int SSW_ENTRY_MODE = 9;
    localparam int SSW_ISSUE_MODE = 8;
    localparam int SSW_FAST = 7;
    localparam int SSW_PAUSED = 6;
    localparam int SSW_KERNEL = 4;
    localparam int SSW_IRQ_HANDLER = 3;
    localparam int SSW_EVT_SEQ = 2;
    localparam int SSW_IRQ_EN = 1;
    localparam int SSW_EVT_EN = 0;

    // Address split for the vector and RAM address builders
    localparam int ADDR_HALF = 16;

endpackage : tile_regs_pkg

`default_nettype wire

// >>> tile_regs_checker.sv
// Bus handshake and side-output timing checks for the tile register bank.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module tile_regs_checker #(
    parameter int MDATA_W = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Side outputs and their causes
    input wire logic [15:0] ram_offset,
    input wire logic [31:0] ram_addr,
    input wire logic event_req,
    input wire logic [15:0] event_vector,
    input wire logic [31:0] vector_addr,
    input wire logic vector_valid,
    input wire logic [MDATA_W-1:0] media_tx_data,
    input wire logic media_tx_clk,
    input wire logic media_ports_en,
    input wire logic debug_entry,
    input wire logic kernel_entry,
    input wire logic [10:0] saved_status_word,
    input wire logic issue_mode_bit,
    input wire logic thread_irq_en,
    input wire logic thread_evt_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_wait_state;
        psel && penable && !pready |=> pready;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("access not answered");
    property p_one_pulse;
        pready |=> !pready;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("ready held too long");
    property p_err_quiet;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("bad error answer");
    property p_ram_low;
        1'h1 |=> ram_addr[15:0] == $past(ram_offset);
    endproperty
    a_ram_low: assert property (p_ram_low) else $error("ram address low half");
    property p_vector;
        event_req |=> vector_valid && vector_addr[15:0] == $past(event_vector);
    endproperty
    a_vector: assert property (p_vector) else $error("vector not built");
    property p_media_off;
        !media_ports_en [*2] |-> !media_tx_clk && media_tx_data == '0;
    endproperty
    a_media_off: assert property (p_media_off) else $error("media active when off");
    property p_capture;
        debug_entry |=> thread_irq_en == $past(saved_status_word[1])
            && thread_evt_en == $past(saved_status_word[0]);
    endproperty
    a_capture: assert property (p_capture) else $error("status not captured");
    property p_issue_hold;
        !kernel_entry |=> $stable(issue_mode_bit);
    endproperty
    a_issue_hold: assert property (p_issue_hold) else $error("issue mode moved");
endmodule : tile_regs_checker

bind tile_control_debug_regs tile_regs_checker #(.MDATA_W(MDATA_W)) u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ram_offset(ram_offset),
    .ram_addr(ram_addr),
    .event_req(event_req),
    .event_vector(event_vector),
    .vector_addr(vector_addr),
    .vector_valid(vector_valid),
    .media_tx_data(media_tx_data),
    .media_tx_clk(media_tx_clk),
    .media_ports_en(media_ports_en),
    .debug_entry(debug_entry),
    .kernel_entry(kernel_entry),
    .saved_status_word(saved_status_word),
    .issue_mode_bit(issue_mode_bit),
    .thread_irq_en(thread_irq_en),
    .thread_evt_en(thread_evt_en)
);

`default_nettype wire

// >>> tile_control_debug_regs_tb.sv
// Self-checking bench for the tile register bank.
// Drives the bus and thread-state inputs directly; no far-side model.
`timescale 1ns/1ps
`default_nettype none

module tile_control_debug_regs_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, ram_addr, vector_addr, rdat;
    logic [15:0] ram_offset, event_vector;
    logic event_req, vector_valid, media_tx_clk, media_ports_en, issue_mode_bit;
    logic all_threads_paused, lp_divider_active, debug_entry, kernel_entry;
    logic [3:0] media_tx_data_in, media_tx_data;
    logic [10:0] saved_status_word;
    logic [31:0] saved_program_counter, saved_stack_pointer;
    logic thread_irq_en, thread_evt_en;
    logic [7:0] addr_tab [6] = '{8'h00, 8'h04, 8'h08, 8'h40, 8'h44, 8'h48};
    logic [31:0] rst_tab [6] = '{32'h0004_0000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] msk_tab [6] = '{32'hffff_fffc, 32'hfffc_0000, 32'h03ff_ff30,
                                 32'h0000_06df, 32'hffff_ffff, 32'hffff_ffff};
    // Per case: expected, dynamic, enable, paused
    logic [3:0] lp_tab [4] = '{4'ha, 4'h6, 4'hf, 4'h1};
    int error_cnt = 0;
    int checks = 0;
    int n;

    tile_control_debug_regs u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ram_offset(ram_offset),
        .ram_addr(ram_addr),
        .event_req(event_req),
        .event_vector(event_vector),
        .vector_addr(vector_addr),
        .vector_valid(vector_valid),
        .media_tx_data_in(media_tx_data_in),
        .media_tx_data(media_tx_data),
        .media_tx_clk(media_tx_clk),
        .media_ports_en(media_ports_en),
        .all_threads_paused(all_threads_paused),
        .lp_divider_active(lp_divider_active),
        .debug_entry(debug_entry),
        .kernel_entry(kernel_entry),
        .saved_status_word(saved_status_word),
        .saved_program_counter(saved_program_counter),
        .saved_stack_pointer(saved_stack_pointer),
        .issue_mode_bit(issue_mode_bit),
        .thread_irq_en(thread_irq_en),
        .thread_evt_en(thread_evt_en)
    );

    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %b, expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // Holds the request until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask : tick

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // Whole run is under two hundred cycles; twenty-five times that means a hang
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        close_out();
    end

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        ram_offset = 16'h0;
        event_req = 1'h0;
        event_vector = 16'h0;
        media_tx_data_in = 4'h0;
        all_threads_paused = 1'h0;
        debug_entry = 1'h0;
        kernel_entry = 1'h0;
        saved_status_word = 11'h0;
        saved_program_counter = 32'h0;
        saved_stack_pointer = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            apb(1'h0, addr_tab[i], 32'h0);
            chk(rdat, rst_tab[i]);
            apb(1'h1, addr_tab[i], 32'hffff_ffff);
            apb(1'h0, addr_tab[i], 32'h0);
            chk(rdat, msk_tab[i]);
        end
        apb(1'h1, 8'h0c, 32'hffff_ffff);
        chk_bit(rerr, 1'h1);
        apb(1'h0, 8'h01, 32'h0);
        chk_bit(rerr, 1'h1);
        $display("test registers done");
        apb(1'h1, 8'h00, 32'h1234_0003);
        ram_offset <= 16'hbeef;
        tick(2);
        chk(ram_addr, 32'h1234_beef);
        apb(1'h1, 8'h04, 32'habcd_ffff);
        event_req <= 1'h1;
        event_vector <= 16'h5a5a;
        @(posedge pclk);
        event_req <= 1'h0;
        #1;
        chk_bit(vector_valid, 1'h1);
        chk(vector_addr, 32'habcc_5a5a);
        $display("test addressing done");
        @(posedge pclk);
        saved_status_word <= 11'h5aa;
        saved_program_counter <= 32'h1357_9bdf;
        saved_stack_pointer <= 32'h2468_ace0;
        debug_entry <= 1'h1;
        @(posedge pclk);
        debug_entry <= 1'h0;
        #1;
        chk_bit(thread_evt_en, 1'h0);
        apb(1'h0, 8'h40, 32'h0);
        chk(rdat, 32'h0000_048a);
        apb(1'h0, 8'h44, 32'h0);
        chk(rdat, 32'h1357_9bdf);
        apb(1'h0, 8'h48, 32'h0);
        chk(rdat, 32'h2468_ace0);
        apb(1'h1, 8'h40, 32'h0000_0200);
        kernel_entry <= 1'h1;
        @(posedge pclk);
        kernel_entry <= 1'h0;
        #1;
        chk_bit(issue_mode_bit, 1'h1);
        chk_bit(thread_irq_en, 1'h0);
        apb(1'h0, 8'h40, 32'h0);
        chk(rdat, 32'h0000_0300);
        $display("test debug done");
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, 8'h08, {26'h0, lp_tab[i][2:1], 4'h0});
            all_threads_paused <= lp_tab[i][0];
            tick(2);
            chk_bit(lp_divider_active, lp_tab[i][3]);
        end
        $display("test low power done");
        // Delay 2, divide by 4, ports on
        apb(1'h1, 8'h08, 32'h0008_0700);
        tick(8);
        chk_bit(media_ports_en, 1'h1);
        n = 0;
        repeat (16) begin
            tick(1);
            n += (media_tx_clk === 1'h1);
        end
        chk(n, 32'h8);
        @(posedge pclk);
        media_tx_data_in <= 4'h9;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (media_tx_data !== 4'h9 && n < 20);
        chk(n, 32'h3);
        $display("test media done");
        close_out();
    end
endmodule : tile_control_debug_regs_tb

`default_nettype wire
